// ==== hdl/cdt_timer.sv ====
// Chained dual down timer with APB registers, pulse pins and interrupt.
// Summary of operation
// - Start flag set in timer mode makes the lead timer decrement every clock.
// - Lead timer mode underflow reloads, keeps counting, sets lead interrupt bit.
// - Follow event mode decrements once per lead underflow.
// - Follow event mode underflow reloads, keeps counting, sets follow interrupt bit.
// - Follow one-shot mode is triggered by a lead underflow while it is stopped; underflows during a shot are ignored.
// - Follow one-shot with pulse output drives its pin high on start.
// - Follow one-shot end drives pin low, reloads, stops, sets interrupt bit.
// - Lead trigger select with start in one-shot mode waits for selected pin edge.
// - Lead one-shot end reloads, stops and sets the lead interrupt bit.
// - Lead pulses reach the pin only while its direction is output.
// - Lead event mode with zero count and the falling edge selected (CTRL_LEDGE clear) interrupts on every falling edge.
//
// Design decisions made here: the APB slave port and the register offsets.
module cdt_timer #(
  parameter int WIDTH = 16
) (
  input wire logic pclk, // Peripheral clock, also the count source.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  output logic irq, // Level interrupt.
  input wire logic lead_timer_io_pin_i, // Lead pin level in.
  output logic lead_timer_io_pin_o, // Lead pin level out.
  output logic lead_timer_io_pin_oe, // Lead pin driven.
  output logic follow_timer_io_pin_o, // Follow pin level out.
  output logic follow_timer_io_pin_oe // Follow pin driven.
);
  if (WIDTH < 2 || WIDTH > 32) begin : g_bad_width
    $error("cdt_timer WIDTH must lie in 2 to 32");
  end

  logic [cdt_pkg::CTRL_W-1:0] ctrl_reg;
  logic [WIDTH-1:0] rld0_reg;
  logic [WIDTH-1:0] rld1_reg;
  logic [1:0] stat_reg;
  logic [1:0] ien_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic irq_reg;
  logic lrun_reg;
  logic frun_reg;
  logic lpin_reg;
  logic fpin_reg;
  logic loe_reg;
  logic foe_reg;
  logic lstart_q_reg;
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic acc;
  logic wr_en;
  logic hit;
  logic [31:0] rdata_next;
  logic act_edge;
  logic fall_edge;
  logic lstart;
  logic fstart;
  logic ltrig;
  logic lstart_rise;
  logic lead_go;
  logic [1:0] dec;
  logic [1:0] load;
  logic [1:0] wrap;
  logic [WIDTH-1:0] count [2];
  logic [WIDTH-1:0] reload [2];
  cdt_pkg::cdt_mode_e lmode;
  cdt_pkg::cdt_mode_e fmode;

  assign lmode = cdt_pkg::cdt_mode_e'(ctrl_reg[cdt_pkg::CTRL_LMODE +: 2]);
  assign fmode = cdt_pkg::cdt_mode_e'(ctrl_reg[cdt_pkg::CTRL_FMODE +: 2]);
  assign lstart = ctrl_reg[cdt_pkg::CTRL_LSTART];
  assign fstart = ctrl_reg[cdt_pkg::CTRL_FSTART];
  assign ltrig = ctrl_reg[cdt_pkg::CTRL_LTRIG];
  assign reload[0] = rld0_reg;
  assign reload[1] = rld1_reg;

  for (genvar i = 0; i < 2; i++) begin : g_ch
    cdt_cnt_if #(.W(WIDTH)) bus ();
    assign bus.load = load[i];
    assign bus.dec = dec[i];
    assign bus.reload = reload[i];
    assign count[i] = bus.count;
    assign wrap[i] = bus.wrap;
    cdt_down_counter #(.W(WIDTH)) u_cnt (
      .pclk(pclk),
      .presetn(presetn),
      .cnt(bus.cnt)
    );
  end

  // Pin synchroniser at the pulled-up idle level, so no false edge follows reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      sync3_reg <= 1'b1;
    end else begin
      sync1_reg <= lead_timer_io_pin_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign fall_edge = ~sync2_reg & sync3_reg;
  assign act_edge = ctrl_reg[cdt_pkg::CTRL_LEDGE] ? (sync2_reg & ~sync3_reg) : fall_edge;

  // APB: one wait state, so every access completes in the second access cycle.
  assign acc = psel & penable;
  assign wr_en = acc & pready_reg & pwrite;

  always_comb begin
    hit = 1'b1;
    rdata_next = 32'h0000_0000;
    case (paddr[7:2])
      cdt_pkg::CTRL_OFS[7:2]: rdata_next[cdt_pkg::CTRL_W-1:0] = ctrl_reg;
      cdt_pkg::LRLD_OFS[7:2]: rdata_next[WIDTH-1:0] = rld0_reg;
      cdt_pkg::FRLD_OFS[7:2]: rdata_next[WIDTH-1:0] = rld1_reg;
      cdt_pkg::LCNT_OFS[7:2]: rdata_next[WIDTH-1:0] = count[0];
      cdt_pkg::FCNT_OFS[7:2]: rdata_next[WIDTH-1:0] = count[1];
      cdt_pkg::STAT_OFS[7:2]: begin
        rdata_next[cdt_pkg::STAT_LIRQ] = stat_reg[0];
        rdata_next[cdt_pkg::STAT_FIRQ] = stat_reg[1];
        rdata_next[cdt_pkg::STAT_LRUN] = lrun_reg;
        rdata_next[cdt_pkg::STAT_FRUN] = frun_reg;
        rdata_next[cdt_pkg::STAT_LPIN] = lpin_reg;
        rdata_next[cdt_pkg::STAT_FPIN] = fpin_reg;
      end
      cdt_pkg::ICLR_OFS[7:2]: rdata_next = 32'h0000_0000;
      cdt_pkg::IEN_OFS[7:2]: rdata_next[1:0] = ien_reg;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= acc & ~pready_reg;
      pslverr_reg <= acc & ~pready_reg & ~hit;
      if (acc && !pready_reg && !pwrite) begin
        prdata_reg <= rdata_next;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= cdt_pkg::CTRL_RST;
      rld0_reg <= cdt_pkg::RLD_RST[WIDTH-1:0];
      rld1_reg <= cdt_pkg::RLD_RST[WIDTH-1:0];
      ien_reg <= cdt_pkg::IRQ_RST;
    end else if (wr_en) begin
      case (paddr[7:2])
        cdt_pkg::CTRL_OFS[7:2]: ctrl_reg <= pwdata[cdt_pkg::CTRL_W-1:0];
        cdt_pkg::LRLD_OFS[7:2]: rld0_reg <= pwdata[WIDTH-1:0];
        cdt_pkg::FRLD_OFS[7:2]: rld1_reg <= pwdata[WIDTH-1:0];
        cdt_pkg::IEN_OFS[7:2]: ien_reg <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // Sticky request bits; a new event wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= cdt_pkg::IRQ_RST;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wrap[i]) begin
          stat_reg[i] <= 1'b1;
        end else if (wr_en && paddr[7:2] == cdt_pkg::ICLR_OFS[7:2] && pwdata[i]) begin
          stat_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(stat_reg & ien_reg);
    end
  end

  // Lead run control.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lstart_q_reg <= 1'b0;
    end else begin
      lstart_q_reg <= lstart;
    end
  end

  assign lstart_rise = lstart & ~lstart_q_reg;
  assign lead_go = ltrig ? act_edge : lstart_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lrun_reg <= 1'b0;
    end else if (!lstart) begin
      lrun_reg <= 1'b0;
    end else begin
      case (lmode)
        cdt_pkg::CDT_ONESHOT: begin
          if (wrap[0]) begin
            lrun_reg <= 1'b0;
          end else if (lead_go) begin
            lrun_reg <= 1'b1;
          end
        end
        default: lrun_reg <= 1'b1;
      endcase
    end
  end

  // Lead counts clocks, or pin edges in event mode; it holds the reload while stopped.
  always_comb begin
    load[0] = ~lrun_reg;
    case (lmode)
      cdt_pkg::CDT_EVENT: dec[0] = lrun_reg & act_edge;
      default: dec[0] = lrun_reg;
    endcase
  end

  // Follow run control.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frun_reg <= 1'b0;
    end else if (!fstart) begin
      frun_reg <= 1'b0;
    end else begin
      case (fmode)
        cdt_pkg::CDT_ONESHOT: begin
          if (wrap[1]) begin
            frun_reg <= 1'b0;
          end else if (wrap[0]) begin
            frun_reg <= 1'b1;
          end
        end
        default: frun_reg <= 1'b1;
      endcase
    end
  end

  always_comb begin
    load[1] = ~frun_reg;
    case (fmode)
      cdt_pkg::CDT_EVENT: dec[1] = frun_reg & wrap[0];
      default: dec[1] = frun_reg;
    endcase
  end

  // Pin levels and drivers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lpin_reg <= 1'b0;
      loe_reg <= 1'b0;
    end else begin
      loe_reg <= ctrl_reg[cdt_pkg::CTRL_LPULSE] & ctrl_reg[cdt_pkg::CTRL_LDIR];
      if (!ctrl_reg[cdt_pkg::CTRL_LPULSE] || lmode != cdt_pkg::CDT_TIMER) begin
        lpin_reg <= 1'b0;
      end else if (wrap[0]) begin
        lpin_reg <= ~lpin_reg;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fpin_reg <= 1'b0;
      foe_reg <= 1'b0;
    end else begin
      foe_reg <= ctrl_reg[cdt_pkg::CTRL_FPULSE];
      if (!ctrl_reg[cdt_pkg::CTRL_FPULSE]) begin
        fpin_reg <= 1'b0;
      end else if (fmode == cdt_pkg::CDT_ONESHOT) begin
        if (wrap[1] || !fstart) begin
          fpin_reg <= 1'b0;
        end else if (wrap[0] && !frun_reg) begin
          fpin_reg <= 1'b1;
        end
      end else if (wrap[1]) begin
        fpin_reg <= ~fpin_reg;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;
  assign lead_timer_io_pin_o = lpin_reg;
  assign lead_timer_io_pin_oe = loe_reg;
  assign follow_timer_io_pin_o = fpin_reg;
  assign follow_timer_io_pin_oe = foe_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  lead_start_a: assert property (
    lstart && lmode == cdt_pkg::CDT_TIMER ##1 lstart && lmode == cdt_pkg::CDT_TIMER
    |-> lrun_reg && dec[0])
    else $error("lead timer not counting after start");
  lead_reload_a: assert property (
    wrap[0] && lmode == cdt_pkg::CDT_TIMER && lstart
    |=> count[0] == $past(rld0_reg) && stat_reg[0] && lrun_reg)
    else $error("lead timer did not reload on underflow");
  follow_cascade_a: assert property (
    frun_reg && fmode == cdt_pkg::CDT_EVENT && fstart && !wrap[0]
    |=> count[1] == $past(count[1]))
    else $error("follow counter moved without lead underflow");
  follow_reload_a: assert property (
    wrap[1] && fmode == cdt_pkg::CDT_EVENT && fstart
    |=> stat_reg[1] && frun_reg && count[1] == $past(rld1_reg))
    else $error("follow event underflow wrong");
  follow_trig_a: assert property (
    fmode == cdt_pkg::CDT_ONESHOT && fstart && wrap[0] && !wrap[1] |=> frun_reg)
    else $error("follow one-shot not triggered");
  follow_high_a: assert property (
    fmode == cdt_pkg::CDT_ONESHOT && fstart && ctrl_reg[cdt_pkg::CTRL_FPULSE]
    && wrap[0] && !frun_reg |=> fpin_reg && frun_reg)
    else $error("follow pin not high at start");
  follow_end_a: assert property (
    wrap[1] && fmode == cdt_pkg::CDT_ONESHOT
    |=> !frun_reg && !fpin_reg && stat_reg[1] && count[1] == $past(rld1_reg))
    else $error("follow one-shot end wrong");
  lead_wait_a: assert property (
    lmode == cdt_pkg::CDT_ONESHOT && ltrig && !lrun_reg && !act_edge |=> !lrun_reg)
    else $error("lead started without trigger edge");
  lead_stop_a: assert property (
    wrap[0] && lmode == cdt_pkg::CDT_ONESHOT
    |=> !lrun_reg && stat_reg[0] && count[0] == $past(rld0_reg))
    else $error("lead one-shot end wrong");
  lead_hiz_a: assert property (
    !ctrl_reg[cdt_pkg::CTRL_LDIR] |=> !lead_timer_io_pin_oe)
    else $error("lead pin driven in input direction");
  edge_irq_a: assert property (
    lmode == cdt_pkg::CDT_EVENT && lrun_reg && lstart && count[0] == '0
    && !ctrl_reg[cdt_pkg::CTRL_LEDGE] && fall_edge |=> stat_reg[0])
    else $error("falling edge gave no lead request");
  lead_toggle_a: assert property (
    wrap[0] && lmode == cdt_pkg::CDT_TIMER && ctrl_reg[cdt_pkg::CTRL_LPULSE]
    |=> lpin_reg != $past(lpin_reg))
    else $error("lead pin did not toggle");
  irq_level_a: assert property (
    (stat_reg & ien_reg) != 2'h0 |=> irq)
    else $error("interrupt output missing");

  cascade_c: cover property (wrap[0] && wrap[1] && fmode == cdt_pkg::CDT_EVENT);
  pwm_c: cover property (fpin_reg ##[1:50] !fpin_reg);
  trig_c: cover property (ltrig && act_edge && !lrun_reg ##1 lrun_reg);
endmodule

// ==== hdl/cdt_pkg.sv ====
// Register map, field positions, reset values and modes of the chained dual down timer.
package cdt_pkg;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] LRLD_OFS = 8'h04;
  localparam logic [7:0] FRLD_OFS = 8'h08;
  localparam logic [7:0] LCNT_OFS = 8'h0C;
  localparam logic [7:0] FCNT_OFS = 8'h10;
  localparam logic [7:0] STAT_OFS = 8'h14;
  localparam logic [7:0] ICLR_OFS = 8'h18;
  localparam logic [7:0] IEN_OFS = 8'h1C;
  localparam int CTRL_LSTART = 0;
  localparam int CTRL_FSTART = 1;
  localparam int CTRL_LMODE = 2;
  localparam int CTRL_FMODE = 4;
  localparam int CTRL_LTRIG = 6;
  localparam int CTRL_LEDGE = 7;
  localparam int CTRL_LPULSE = 8;
  localparam int CTRL_FPULSE = 9;
  localparam int CTRL_LDIR = 10;
  localparam int CTRL_W = 11;
  localparam int STAT_LIRQ = 0;
  localparam int STAT_FIRQ = 1;
  localparam int STAT_LRUN = 2;
  localparam int STAT_FRUN = 3;
  localparam int STAT_LPIN = 4;
  localparam int STAT_FPIN = 5;
  localparam logic [10:0] CTRL_RST = 11'h000;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam logic [31:0] RLD_RST = 32'h0000_0000;
  typedef enum logic [1:0] {
    CDT_TIMER = 2'b00,
    CDT_EVENT = 2'b01,
    CDT_ONESHOT = 2'b10
  } cdt_mode_e;
endpackage

// ==== hdl/cdt_cnt_if.sv ====
// Signals between the timer core and one down-counter channel.
interface cdt_cnt_if #(parameter int W = 16);
  logic load;
  logic dec;
  logic [W-1:0] reload;
  logic [W-1:0] count;
  logic wrap;
  modport ctl (output load, output dec, output reload, input count, input wrap);
  modport cnt (input load, input dec, input reload, output count, output wrap);
endinterface

// ==== hdl/cdt_down_counter.sv ====
// One reloadable down-counter channel.
module cdt_down_counter #(
  parameter int W = 16
) (
  input wire logic pclk, // Peripheral clock.
  input wire logic presetn, // Asynchronous reset, active low.
  cdt_cnt_if.cnt cnt // Control and count.
);
  logic [W-1:0] count_reg;

  // A decrement at zero reloads, so a reload of n spans n plus one steps.
  assign cnt.wrap = cnt.dec & ~cnt.load & (count_reg == '0);
  assign cnt.count = count_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
    end else if (cnt.load) begin
      count_reg <= cnt.reload;
    end else if (cnt.dec) begin
      if (count_reg == '0) begin
        count_reg <= cnt.reload;
      end else begin
        count_reg <= count_reg - W'(1);
      end
    end
  end
endmodule

// ==== verif/cdt_pin_partner.sv ====
// Model of the board around the two timer pins: pull-ups and an external trigger source.
module cdt_pin_partner (
  input wire logic lead_o, // Lead pin level from the block.
  input wire logic lead_oe, // Lead pin driven by the block.
  input wire logic follow_o, // Follow pin level from the block.
  input wire logic follow_oe, // Follow pin driven by the block.
  input wire logic ext_low, // External source pulls the lead pin low.
  output logic lead_level, // Resolved lead pin level.
  output logic follow_level // Resolved follow pin level.
);
  timeunit 1ns;
  timeprecision 1ps;
  // Both pins carry pull-ups, so a released pin reads high.
  // The external source only makes its trigger edges while the block lets go of the pin.
  assign lead_level = lead_oe ? lead_o : !ext_low;
  assign follow_level = follow_oe ? follow_o : 1'b1;
endmodule

// ==== verif/chained_dual_down_timer_tb.sv ====
// Self-checking testbench of the chained dual down timer.
module chained_dual_down_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ext_low = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, irq, lead_o, lead_oe, follow_o, follow_oe, lead_level, follow_level;
  int failures = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic er;
  int c;

  always #25 pclk = ~pclk;

  cdt_timer #(.WIDTH(16)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .lead_timer_io_pin_i(lead_level),
    .lead_timer_io_pin_o(lead_o), .lead_timer_io_pin_oe(lead_oe),
    .follow_timer_io_pin_o(follow_o), .follow_timer_io_pin_oe(follow_oe));

  cdt_pin_partner board (.lead_o(lead_o), .lead_oe(lead_oe), .follow_o(follow_o),
    .follow_oe(follow_oe), .ext_low(ext_low), .lead_level(lead_level),
    .follow_level(follow_level));

  task automatic wrap_up();
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_cycles(input int got, input int exp, input string what);
    samples_checked++;
    if (got != exp) begin
      failures++;
      $display("unexpected at %0t: %s took %0d cycles, want %0d", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      failures++;
      $display("unexpected at %0t: no bus answer", $time);
      wrap_up();
    end
  endtask

  function automatic logic pick(input int s);
    return (s == 0) ? lead_level : (s == 1) ? follow_level : irq;
  endfunction

  // Counts clocks until the chosen signal changes; returns the bound if it never does.
  task automatic meas(input int s, input int bound, output int n);
    logic prev;
    prev = pick(s);
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (pick(s) === prev && n < bound);
  endtask

  task automatic stop_all();
    apb(cdt_pkg::CTRL_OFS, 1'b1, 32'h0000_0000);
    apb(cdt_pkg::ICLR_OFS, 1'b1, 32'h0000_0003);
  endtask

  task automatic t_reset_map();
    apb(cdt_pkg::CTRL_OFS, 1'b0, 32'h0000_0000);
    chk_word(rd, 32'h0000_0000, "control after reset");
    apb(cdt_pkg::STAT_OFS, 1'b0, 32'h0000_0000);
    chk_word(rd, 32'h0000_0000, "status after reset");
    apb(8'h20, 1'b0, 32'h0000_0000);
    chk_word({31'h0000_0000, er}, 32'h0000_0001, "unmapped error");
    apb(cdt_pkg::LRLD_OFS, 1'b1, 32'h0000_1234);
    apb(cdt_pkg::LCNT_OFS, 1'b0, 32'h0000_0000);
    chk_word(rd, 32'h0000_1234, "stopped count shows reload");
  endtask

  task automatic t_lead_pulse();
    apb(cdt_pkg::LRLD_OFS, 1'b1, 32'h0000_0003);
    apb(cdt_pkg::IEN_OFS, 1'b1, 32'h0000_0001);
    apb(cdt_pkg::CTRL_OFS, 1'b1, 32'h0000_0501);
    meas(0, 20, c);
    meas(0, 20, c);
    chk_cycles(c, 4, "lead toggle");
    meas(0, 20, c);
    chk_cycles(c, 4, "lead toggle again");
    chk_word({31'h0000_0000, irq}, 32'h0000_0001, "lead irq");
    apb(cdt_pkg::IEN_OFS, 1'b1, 32'h0000_0000);
    meas(2, 3, c);
    chk_word({31'h0000_0000, irq}, 32'h0000_0000, "masked irq");
    apb(cdt_pkg::CTRL_OFS, 1'b1, 32'h0000_0101);
    meas(0, 3, c);
    chk_word({31'h0000_0000, lead_oe}, 32'h0000_0000, "lead pin released");
    meas(0, 20, c);
    chk_cycles(c, 20, "pulses stopped at input pin");
    stop_all();
    apb(cdt_pkg::IEN_OFS, 1'b1, 32'h0000_0003);
    apb(cdt_pkg::STAT_OFS, 1'b0, 32'h0000_0000);
    chk_word(rd & 32'h0000_0003, 32'h0000_0000, "status cleared");
    chk_word({31'h0000_0000, irq}, 32'h0000_0000, "irq cleared");
  endtask

  task automatic t_cascade();
    apb(cdt_pkg::LRLD_OFS, 1'b1, 32'h0000_0001);
    apb(cdt_pkg::FRLD_OFS, 1'b1, 32'h0000_0002);
    apb(cdt_pkg::CTRL_OFS, 1'b1, 32'h0000_0213);
    meas(1, 30, c);
    meas(1, 30, c);
    chk_cycles(c, 6, "follow event period");
    apb(cdt_pkg::STAT_OFS, 1'b0, 32'h0000_0000);
    chk_word(rd & 32'h0000_000F, 32'h0000_000F, "cascade status");
    stop_all();
  endtask

  task automatic t_pwm();
    apb(cdt_pkg::LRLD_OFS, 1'b1, 32'h0000_0009);
    apb(cdt_pkg::FRLD_OFS, 1'b1, 32'h0000_0003);
    apb(cdt_pkg::CTRL_OFS, 1'b1, 32'h0000_0223);
    meas(1, 30, c);
    if (follow_level !== 1'b1) meas(1, 30, c);
    meas(1, 30, c);
    chk_cycles(c, 4, "pwm high width");
    meas(1, 30, c);
    chk_cycles(c, 6, "pwm low width");
    apb(cdt_pkg::STAT_OFS, 1'b0, 32'h0000_0000);
    chk_word(rd & 32'h0000_0002, 32'h0000_0002, "follow one-shot request");
    stop_all();
  endtask

  task automatic t_delayed();
    apb(cdt_pkg::LRLD_OFS, 1'b1, 32'h0000_0005);
    apb(cdt_pkg::FRLD_OFS, 1'b1, 32'h0000_0002);
    apb(cdt_pkg::CTRL_OFS, 1'b1, 32'h0000_026B);
    // The follow pin is taken over by the block and falls to its idle low first.
    meas(1, 2, c);
    meas(1, 20, c);
    chk_cycles(c, 20, "no start before trigger");
    apb(cdt_pkg::LCNT_OFS, 1'b0, 32'h0000_0000);
    chk_word(rd, 32'h0000_0005, "lead held before trigger");
    @(posedge pclk);
    ext_low <= 1'b1;
    meas(1, 40, c);
    meas(1, 20, c);
    chk_cycles(c, 3, "delayed pulse width");
    @(posedge pclk);
    ext_low <= 1'b0;
    meas(1, 20, c);
    chk_cycles(c, 20, "no retrigger on other edge");
    apb(cdt_pkg::STAT_OFS, 1'b0, 32'h0000_0000);
    chk_word(rd & 32'h0000_000F, 32'h0000_0003, "both stopped with requests");
    apb(cdt_pkg::LCNT_OFS, 1'b0, 32'h0000_0000);
    chk_word(rd, 32'h0000_0005, "lead reloaded");
    stop_all();
  endtask

  task automatic t_ext_irq();
    apb(cdt_pkg::LRLD_OFS, 1'b1, 32'h0000_0000);
    apb(cdt_pkg::CTRL_OFS, 1'b1, 32'h0000_0005);
    for (int i = 0; i < 2; i++) begin
      ext_low <= 1'b1;
      meas(2, 10, c);
      apb(cdt_pkg::STAT_OFS, 1'b0, 32'h0000_0000);
      chk_word(rd & 32'h0000_0001, 32'h0000_0001, "falling edge request");
      apb(cdt_pkg::ICLR_OFS, 1'b1, 32'h0000_0001);
      ext_low <= 1'b0;
      meas(2, 10, c);
      apb(cdt_pkg::STAT_OFS, 1'b0, 32'h0000_0000);
      chk_word(rd & 32'h0000_0001, 32'h0000_0000, "rising edge quiet");
    end
    stop_all();
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_map();
    t_lead_pulse();
    t_cascade();
    t_pwm();
    t_delayed();
    t_ext_irq();
    wrap_up();
  end
endmodule
